// File: shutdown_regs_pkg.sv
package shutdown_regs_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] SHUTDOWN_CAUSE_LATCH_OFS = 8'h05;
	localparam logic [7:0] FIRST_CTRL_OFS = 8'h20;
	localparam logic [7:0] SECOND_CTRL_OFS = 8'h21;
	localparam logic [7:0] THIRD_DECAY_OFS = 8'h22;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int COLD_OFF_BIT = 3;
	localparam int UNDERVOLTAGE_BIT = 2;
	localparam int RAIL_FAULT_BIT = 1;
	localparam int CRIT_HEAT_BIT = 0;
	localparam int DECAY_BIT = 0;
	localparam int CODE_MSB = 7;
	localparam int CODE_LSB = 1;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [3:0] CAUSE_RESET = 4'h0;
	localparam logic [7:0] READ_IDLE = 8'h00;
	// factory defaults; each variant overrides them through the module parameters
	localparam logic [7:0] FIRST_CTRL_FACTORY = 8'h00;
	localparam logic [7:0] SECOND_CTRL_FACTORY = 8'h00;
	localparam logic [7:0] THIRD_DECAY_FACTORY = 8'h00;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic supply_undervoltage;
		logic rail_fault;
		logic critical_heat;
	} shutdown_event_t;

	typedef struct packed {
		logic [6:0] code;
		logic decay_select;
	} controller_ctrl_t;

endpackage

// File: cause_flag.sv
`timescale 1ns/1ns
module cause_flag
(
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	input wire logic i_set,
	input wire logic i_clear,
	output logic o_flag
);
	import shutdown_regs_pkg::*;

	logic flag_ff;

	// set wins over a clear in the same cycle
	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			flag_ff <= 1'b0;
		else if (i_ce)
			flag_ff <= i_set | (flag_ff & ~i_clear);
	end

	assign o_flag = flag_ff;
endmodule

// File: shutdown_source_and_buck_control_regs.sv
`timescale 1ns/1ns
// Behaviour
// (RULE1) cause flags device-set, host write-one clears
// (RULE2) undervoltage shutdown sets bit 2
// (RULE3) unmasked rail fault shutdown sets bit 1
// (RULE4) critical die heat sets bit 0
// (RULE5) any cause set raises summary flag
// (RULE6) cold-off flag never set, reads zero
// (RULE7) cause latch at 0x05, resets zero
// (RULE8) first controller code in bits 7:1
// (RULE9) second controller code in bits 7:1
// (RULE10) bit 0 picks slew or passive decay
// (RULE11) third decay at 0x22, spare bits stored
// (RULE12) controllers at 0x20/0x21, factory reset values
// (RULE13) host clears causes before summary flag
// (RULE14) cause latch bits 7:4 read zero
// (RULE15) new cause beats simultaneous clear
module shutdown_source_and_buck_control_regs
#(
	parameter logic [7:0] FIRST_CTRL_RESET = shutdown_regs_pkg::FIRST_CTRL_FACTORY,
	parameter logic [7:0] SECOND_CTRL_RESET = shutdown_regs_pkg::SECOND_CTRL_FACTORY,
	parameter logic [7:0] THIRD_DECAY_RESET = shutdown_regs_pkg::THIRD_DECAY_FACTORY
)
(
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	input wire shutdown_regs_pkg::reg_req_t i_req,
	input wire shutdown_regs_pkg::shutdown_event_t i_shutdown_event,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	output logic o_shutdown_summary_set,
	output shutdown_regs_pkg::controller_ctrl_t o_first_ctrl,
	output shutdown_regs_pkg::controller_ctrl_t o_second_ctrl,
	output logic o_third_decay_select
);
	import shutdown_regs_pkg::*;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	function automatic logic hit(input reg_req_t r, input logic [7:0] ofs);
		hit = r.addr == ofs;
	endfunction

	function automatic logic rising(input logic cur, input logic prev);
		rising = cur & ~prev;
	endfunction

	// split a controller register into voltage code and decay select
	function automatic controller_ctrl_t unpack_ctrl(input logic [7:0] r);
		unpack_ctrl.code = r[CODE_MSB:CODE_LSB]; // [RULE8] [RULE9]
		unpack_ctrl.decay_select = r[DECAY_BIT]; // [RULE10]
	endfunction

	logic cause_wr;
	logic first_wr;
	logic second_wr;
	logic third_wr;
	logic [3:0] cause_clear;
	logic [3:0] cause_set;
	logic [3:0] cause_flags;

	assign cause_wr = i_req.wr & hit(i_req, SHUTDOWN_CAUSE_LATCH_OFS);
	assign cause_clear = cause_wr ? i_req.wdata[3:0] : 4'h0; // [RULE1]

	// write strobes for the controller registers
	assign first_wr = i_req.wr & hit(i_req, FIRST_CTRL_OFS);
	assign second_wr = i_req.wr & hit(i_req, SECOND_CTRL_OFS);
	assign third_wr = i_req.wr & hit(i_req, THIRD_DECAY_OFS);

	// ------------------------------------------------------------
	// event sources, one set pulse per rising event
	// ------------------------------------------------------------
	// asynchronous levels: two flops before anything reads them
	// prev resets low, the idle level, so reset makes no false edge
	shutdown_event_t evt_meta_ff;
	shutdown_event_t evt_sync_ff;
	shutdown_event_t evt_prev_ff;

	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			evt_meta_ff <= '0;
			evt_sync_ff <= '0;
			evt_prev_ff <= '0;
		end
		else if (i_ce)
		begin
			evt_meta_ff <= i_shutdown_event;
			evt_sync_ff <= evt_meta_ff;
			evt_prev_ff <= evt_sync_ff;
		end
	end

	assign cause_set[COLD_OFF_BIT] = 1'b0; // [RULE6]
	assign cause_set[UNDERVOLTAGE_BIT] = rising(evt_sync_ff.supply_undervoltage, evt_prev_ff.supply_undervoltage); // [RULE2]
	assign cause_set[RAIL_FAULT_BIT] = rising(evt_sync_ff.rail_fault, evt_prev_ff.rail_fault); // [RULE3]
	assign cause_set[CRIT_HEAT_BIT] = rising(evt_sync_ff.critical_heat, evt_prev_ff.critical_heat); // [RULE4]

	// ------------------------------------------------------------
	// cause latch
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_flag
			cause_flag u_flag
			(
				.i_ref_clk(i_ref_clk),
				.i_sys_rst(i_sys_rst),
				.i_ce(i_ce),
				.i_set(cause_set[g]), // [RULE15]
				.i_clear(cause_clear[g]), // [RULE1]
				.o_flag(cause_flags[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// summary pulse toward the interrupt register
	// ------------------------------------------------------------
	logic nxt_summary_set;

	// one pulse per cycle in which a cause rises, on the edge that sets the flag
	assign nxt_summary_set = |cause_set[2:0]; // [RULE5]

	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_shutdown_summary_set <= 1'b0;
		else if (i_ce)
			o_shutdown_summary_set <= nxt_summary_set; // [RULE5]
	end

	// ------------------------------------------------------------
	// controller registers
	// ------------------------------------------------------------
	logic [7:0] first_ctrl_ff;
	logic [7:0] second_ctrl_ff;
	logic [7:0] third_decay_ff;

	// first controller: voltage code and decay select
	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			first_ctrl_ff <= FIRST_CTRL_RESET; // [RULE12]
		else if (i_ce && first_wr)
			first_ctrl_ff <= i_req.wdata; // [RULE8]
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			second_ctrl_ff <= SECOND_CTRL_RESET; // [RULE12]
		else if (i_ce && second_wr)
			second_ctrl_ff <= i_req.wdata; // [RULE9]
	end

	// third controller: decay select plus spare storage
	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			third_decay_ff <= THIRD_DECAY_RESET; // [RULE11]
		else if (i_ce && third_wr)
			third_decay_ff <= i_req.wdata; // [RULE11]
	end

	// ------------------------------------------------------------
	// controller outputs, one cycle behind storage
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_first_ctrl <= '0;
		else if (i_ce)
			o_first_ctrl <= unpack_ctrl(first_ctrl_ff); // [RULE8] [RULE10]
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_second_ctrl <= '0;
		else if (i_ce)
			o_second_ctrl <= unpack_ctrl(second_ctrl_ff); // [RULE9] [RULE10]
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_third_decay_select <= 1'b0;
		else if (i_ce)
			o_third_decay_select <= third_decay_ff[DECAY_BIT]; // [RULE10]
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	logic [7:0] nxt_rdata;

	always_comb
	begin
		nxt_rdata = READ_IDLE;
		case (i_req.addr)
			SHUTDOWN_CAUSE_LATCH_OFS: nxt_rdata = {4'h0, cause_flags}; // [RULE14] [RULE7]
			FIRST_CTRL_OFS: nxt_rdata = first_ctrl_ff;
			SECOND_CTRL_OFS: nxt_rdata = second_ctrl_ff;
			THIRD_DECAY_OFS: nxt_rdata = third_decay_ff;
			default: nxt_rdata = READ_IDLE;
		endcase
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_rdata <= READ_IDLE;
			o_rvalid <= 1'b0;
		end
		else if (i_ce)
		begin
			o_rvalid <= i_req.rd;
			if (i_req.rd)
				o_rdata <= nxt_rdata;
		end
	end
endmodule

// File: shutdown_env.sv
`timescale 1ns/1ns
module shutdown_env
(
	input wire logic [2:0] i_cause,
	output shutdown_regs_pkg::shutdown_event_t o_event
);
	import shutdown_regs_pkg::*;
	// cause levels held while the condition lasts
	assign o_event = i_cause;
endmodule

// File: shutdown_regs_assertions.sv
`timescale 1ns/1ns
module shutdown_regs_assertions
(
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	input wire shutdown_regs_pkg::reg_req_t i_req,
	input wire shutdown_regs_pkg::shutdown_event_t i_shutdown_event,
	input wire logic [7:0] o_rdata,
	input wire logic o_rvalid,
	input wire logic o_shutdown_summary_set,
	input wire shutdown_regs_pkg::controller_ctrl_t o_first_ctrl,
	input wire shutdown_regs_pkg::controller_ctrl_t o_second_ctrl,
	input wire logic o_third_decay_select
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	sequence rd_at(logic [7:0] a);
		i_ce && i_req.rd && i_req.addr == a;
	endsequence
	sequence wr_at(logic [7:0] a);
		i_ce && i_req.wr && i_req.addr == a;
	endsequence
	sequence summary_pulse;
		##[2:5] o_shutdown_summary_set;
	endsequence
	rvalid_pulse_a: assert property (i_ce && i_req.rd |=> o_rvalid)
		else $error("no read answer");
	rsvd_zero_a: assert property (rd_at(8'h05) |=> o_rdata[7:4] == 4'h0)
		else $error("reserved bits set");
	cold_off_a: assert property (rd_at(8'h05) |=> !o_rdata[3])
		else $error("cold-off set");
	unmapped_read_a: assert property (rd_at(8'h10) |=> o_rdata == 8'h00)
		else $error("unmapped data");
	first_ctrl_a: assert property (wr_at(8'h20) |=> ##1 o_first_ctrl == $past(i_req.wdata, 2))
		else $error("first ctrl lost");
	second_ctrl_a: assert property (wr_at(8'h21) |=> ##1 o_second_ctrl == $past(i_req.wdata, 2))
		else $error("second ctrl lost");
	third_decay_a: assert property (wr_at(8'h22) |=> ##1 o_third_decay_select == $past(i_req.wdata[0], 2))
		else $error("third decay lost");
	heat_summary_a: assert property ($rose(i_shutdown_event.critical_heat) |-> summary_pulse)
		else $error("no summary pulse on heat");
	uv_summary_a: assert property ($rose(i_shutdown_event.supply_undervoltage) |-> summary_pulse)
		else $error("no summary pulse on undervoltage");
	rail_summary_a: assert property ($rose(i_shutdown_event.rail_fault) |-> summary_pulse)
		else $error("no summary pulse on rail fault");
endmodule
bind shutdown_source_and_buck_control_regs shutdown_regs_assertions u_shutdown_regs_assertions (.i_ref_clk, .i_sys_rst,
	.i_ce, .i_req, .i_shutdown_event, .o_rdata, .o_rvalid, .o_shutdown_summary_set, .o_first_ctrl, .o_second_ctrl,
	.o_third_decay_select);

// File: tb_top.sv
`timescale 1ns/1ns
module tb_top;
	import shutdown_regs_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [2:0] cause = 3'h0;
	reg_req_t req = '0;
	shutdown_event_t ev;
	logic [7:0] rdata;
	logic rvalid, sum, d3;
	controller_ctrl_t c1, c2;
	int err_total = 0;
	int n_compared = 0;
	int n_summary = 0;
	initial forever #5 clk = ~clk;
	// summary pulses last one cycle, so each meets exactly one falling edge
	always @(negedge clk)
		if (sum === 1'b1)
			n_summary++;
	shutdown_env u_shutdown_env (.i_cause(cause), .o_event(ev));
	shutdown_source_and_buck_control_regs u_shutdown_source_and_buck_control_regs (.i_ref_clk(clk), .i_sys_rst(rst),
		.i_ce(ce), .i_req(req), .i_shutdown_event(ev), .o_rdata(rdata), .o_rvalid(rvalid),
		.o_shutdown_summary_set(sum), .o_first_ctrl(c1), .o_second_ctrl(c2), .o_third_decay_select(d3));
	task chk(input logic [7:0] a, input logic [7:0] e);
		n_compared++;
		if (a !== e)
		begin
			$display("[ERR] %0t got %h exp %h", $time, a, e);
			err_total++;
		end
	endtask
	task complete_run;
		$display("errors %0d compares %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		@(negedge clk);
		req.wr = 1'b0;
		@(negedge clk);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		int k;
		req.rd = 1'b1;
		req.addr = a;
		@(negedge clk);
		req.rd = 1'b0;
		for (k = 0; k < 4 && rvalid !== 1'b1; k++)
			@(negedge clk);
		if (k == 4)
		begin
			err_total++;
			complete_run();
		end
		else
			chk(rdata, e);
		@(negedge clk);
	endtask
	initial
	begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		rd(8'h05, 8'h00);
		rd(8'h20, FIRST_CTRL_FACTORY);
		rd(8'h21, SECOND_CTRL_FACTORY);
		rd(8'h22, THIRD_DECAY_FACTORY);
		wr(8'h20, 8'hb5);
		wr(8'h21, 8'h6a);
		wr(8'h22, 8'hff);
		wr(8'h06, 8'h77);
		rd(8'h20, 8'hb5);
		rd(8'h21, 8'h6a);
		rd(8'h22, 8'hff);
		rd(8'h10, 8'h00);
		chk(c1, 8'hb5);
		chk(c2, 8'h6a);
		chk({7'h0, d3}, 8'h01);
		// clock enable low: this write must not land
		ce = 1'b0;
		wr(8'h20, 8'h3c);
		ce = 1'b1;
		rd(8'h20, 8'hb5);
		for (int i = 0; i < 3; i++)
		begin
			cause[2 - i] = 1'b1;
			repeat (8) @(negedge clk);
			rd(8'h05, {5'h0, cause});
		end
		chk(8'(n_summary), 8'h03);
		wr(8'h05, 8'h00);
		rd(8'h05, 8'h07);
		wr(8'h05, 8'hf2);
		rd(8'h05, 8'h05);
		// causes are cleared before any summary clear outside the block
		wr(8'h05, 8'h05);
		rd(8'h05, 8'h00);
		// a new heat event lands on the same edge as its clear
		cause = 3'h0;
		repeat (4) @(negedge clk);
		cause[0] = 1'b1;
		repeat (2) @(negedge clk);
		wr(8'h05, 8'h01);
		rd(8'h05, 8'h01);
		chk(8'(n_summary), 8'h04);
		// mid-run reset with the event inputs idle
		cause = 3'h0;
		repeat (4) @(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		rd(8'h05, 8'h00);
		rd(8'h20, FIRST_CTRL_FACTORY);
		chk(c1, FIRST_CTRL_FACTORY);
		chk(8'(n_summary), 8'h04);
		complete_run();
	end
endmodule
